/* core/lcdm_drive_top.sv */
`timescale 1ns/10ps
module lcdm_drive_top #(
  parameter int SEG_NUM = 36,
  parameter int SLICE_CYCLES = lcdm_pkg::SLICE_CYCLES_DFLT,
  parameter int BLINK_FRAMES = lcdm_pkg::BLINK_FRAMES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [SEG_NUM-1:0][lcdm_pkg::LVL_W-1:0] segLevel,
  output logic [3:0][lcdm_pkg::LVL_W-1:0] comLevel,
  output logic [3:0] sharedIsCom,
  output logic [1:0] genSel,
  output logic [3:0] refLevel
);
  import lcdm_pkg::*;

  localparam int CW = $clog2(SLICE_CYCLES + 1);
  localparam int BW = $clog2(BLINK_FRAMES + 1);

  // ==========================================================
  // helpers
  function automatic logic isDmem(input logic [19:0] a);
    logic [19:0] top;
    top = DMEM_BASE + 20'(4 * SEG_NUM);
    return a >= DMEM_BASE && a < top && a[1:0] == 2'h0;
  endfunction

  function automatic logic [5:0] dmemIdx(input logic [19:0] a);
    logic [19:0] off;
    off = a - DMEM_BASE;
    return off[7:2];
  endfunction

  function automatic logic [LVL_W-1:0] comLvl(
    input logic sel,
    input logic pol,
    input logic [2:0] den
  );
    if (sel) begin
      return pol ? den : 3'h0;
    end
    return pol ? 3'h1 : den - 3'h1;
  endfunction

  function automatic logic [LVL_W-1:0] segLvl(
    input logic on,
    input logic pol,
    input logic [2:0] den
  );
    if (on) begin
      return pol ? 3'h0 : den;
    end
    if (den == 3'h1) begin
      return pol ? den : 3'h0;
    end
    if (den == 3'h2) begin
      return 3'h1;
    end
    return pol ? 3'h2 : den - 3'h2;
  endfunction

  // ==========================================================
  // state
  lcdm_mode_cfg_t modeCfg_q;
  lcdm_ctrl_t ctrl_q;
  logic [7:0] dispMem_q [SEG_NUM];
  lcdm_mode_t mode;
  lcdm_state_t state_q;
  lcdm_state_t state_d;
  logic [CW-1:0] sliceCnt_q;
  logic [2:0] sliceIdx_q;
  logic pol_q;
  logic [BW-1:0] blinkCnt_q;
  logic wrPend_q;
  logic [19:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [SEG_NUM-1:0][LVL_W-1:0] segLevel_q;
  logic [3:0][LVL_W-1:0] comLevel_q;
  logic [3:0] sharedIsCom_q;
  logic [1:0] genSel_q;
  logic [3:0] refLevel_q;

  lcdm_mode_decode #(
    .SEG_NUM(SEG_NUM)
  ) u_decode (
    .cfg(modeCfg_q),
    .mode(mode)
  );

  // ==========================================================
  // bus decode
  wire addrPhase = hsel && htrans[1] && hready;
  wire [19:0] rdAddr = haddr[19:0];
  wire rdDmem = isDmem(rdAddr);
  wire wrDmem = isDmem(wrAddr_q);
  wire [5:0] rdIdx = dmemIdx(rdAddr);
  wire [5:0] wrIdx = dmemIdx(wrAddr_q);
  // hsize is ignored: every writable register is one byte in the low lane
  // only the low byte lane is used; byte writes to the word base fit it
  wire [7:0] wrByte = hwdata[7:0]; // R2
  lcdm_status_t status;
  assign status.zero = 15'h0;
  assign status.segCount = mode.segCount;
  assign status.comCount = mode.comCount;
  assign status.pol = pol_q;
  assign status.slice = sliceIdx_q;
  assign status.blank = state_q == ST_BLANK;
  assign status.run = state_q == ST_RUN;
  assign status.valid = mode.valid;
  logic [31:0] rdMux;
  always_comb begin
    if (rdAddr == MODE_CFG_OFS) begin
      rdMux = {24'h0, modeCfg_q};
    end else if (rdAddr == CTRL_OFS) begin
      rdMux = {24'h0, ctrl_q};
    end else if (rdAddr == STATUS_OFS) begin
      rdMux = status;
    end else if (rdDmem) begin
      rdMux = {24'h0, dispMem_q[rdIdx]};
    end else begin
      rdMux = 32'h0;
    end
  end

  // ==========================================================
  // bus slave: zero wait states, read data fetched at the
  // address phase so the data-phase output is a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 20'h0;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= rdAddr;
      if (addrPhase && !hwrite) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeCfg_q <= MODE_CFG_RST; // R1
      ctrl_q <= CTRL_RST;
    end else if (wrPend_q) begin
      if (wrAddr_q == MODE_CFG_OFS) begin
        modeCfg_q <= wrByte; // R3 R4 R5 R6
      end
      if (wrAddr_q == CTRL_OFS) begin
        ctrl_q <= wrByte;
      end
    end
  end

  // display memory: one bit per common slice for each segment pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SEG_NUM; i++) begin
        dispMem_q[i] <= 8'h00;
      end
    end else if (wrPend_q && wrDmem) begin
      dispMem_q[wrIdx] <= wrByte;
    end
  end

  // ==========================================================
  // slice timing
  wire runEn = ctrl_q.dispOn && mode.valid; // R17
  wire sliceTick = sliceCnt_q == CW'(SLICE_CYCLES - 1);
  wire [3:0] lastSlice = mode.comCount - 4'h1;
  wire frameEnd = sliceTick && {1'b0, sliceIdx_q} == lastSlice;
  // style A flips polarity every slice, style B once per frame
  wire polFlip = modeCfg_q.waveB ? frameEnd : sliceTick; // R4
  wire blinkEnd = frameEnd && blinkCnt_q == BW'(BLINK_FRAMES - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sliceCnt_q <= '0;
      sliceIdx_q <= 3'h0;
      pol_q <= 1'b0;
    end else if (!runEn) begin
      sliceCnt_q <= '0;
      sliceIdx_q <= 3'h0;
      pol_q <= 1'b0;
    end else begin
      sliceCnt_q <= sliceTick ? '0 : sliceCnt_q + CW'(1);
      if (frameEnd) begin
        sliceIdx_q <= 3'h0;
      end else if (sliceTick) begin
        sliceIdx_q <= sliceIdx_q + 3'h1; // R8
      end
      if (polFlip) begin
        pol_q <= !pol_q;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blinkCnt_q <= '0;
    end else if (state_q == ST_OFF || !ctrl_q.blinkEn) begin
      blinkCnt_q <= '0;
    end else if (blinkEnd) begin
      blinkCnt_q <= '0;
    end else if (frameEnd) begin
      blinkCnt_q <= blinkCnt_q + BW'(1);
    end
  end

  // ==========================================================
  // display state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (runEn) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!runEn) begin
          state_d = ST_OFF;
        end else if (ctrl_q.blinkEn && blinkEnd) begin
          state_d = ST_BLANK; // R9
        end
      end
      ST_BLANK: begin
        if (!runEn) begin
          state_d = ST_OFF;
        end else if (!ctrl_q.blinkEn || blinkEnd) begin
          state_d = ST_RUN; // R9
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // pin level selection
  wire blank = state_q == ST_BLANK;
  wire [2:0] den = mode.biasDen;
  logic [SEG_NUM-1:0][LVL_W-1:0] segLevelD;
  logic [3:0][LVL_W-1:0] comLevelD;
  logic [3:0] sharedD;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_com
      wire used = 4'(g) < mode.comCount;
      assign comLevelD[g] = used ? comLvl(sliceIdx_q == 3'(g), pol_q, den) : '0;
      // a shared pin serves as a common once the slice count exceeds its common number
      assign sharedD[g] = mode.comCount > 4'(g + SHARED_PINS); // R10
    end
    for (g = 0; g < SEG_NUM; g++) begin : g_seg
      wire on = dispMem_q[g][sliceIdx_q] && !blank; // R8 R9
      wire [LVL_W-1:0] sLvl = segLvl(on, pol_q, den);
      if (g < SHARED_PINS) begin : g_shared
        wire [LVL_W-1:0] cLvl = comLvl(sliceIdx_q == 3'(g + SHARED_PINS), pol_q, den);
        assign segLevelD[g] = sharedD[g] ? cLvl : sLvl; // R10 R11 R12
      end else begin : g_plain
        assign segLevelD[g] = sLvl; // R13 R16
      end
    end
  endgenerate

  // ==========================================================
  // output registers; idle or illegal modes drive ground level
  // gating on runEn too keeps a freshly illegal mode from leaking
  // one cycle of waveform before the state machine drops to off
  wire outIdle = state_q == ST_OFF || !runEn; // R17
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      segLevel_q <= '0;
      comLevel_q <= '0;
      sharedIsCom_q <= 4'h0;
    end else if (outIdle) begin
      segLevel_q <= '0; // R17
      comLevel_q <= '0; // R17
      sharedIsCom_q <= 4'h0;
    end else begin
      segLevel_q <= segLevelD;
      comLevel_q <= comLevelD;
      sharedIsCom_q <= sharedD; // R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      genSel_q <= GEN_EXT;
    end else begin
      genSel_q <= mode.valid ? modeCfg_q.genSel : GEN_EXT; // R3
    end
  end

  // contrast only means something to a legal boost mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refLevel_q <= 4'h0;
    end else begin
      refLevel_q <= mode.valid && modeCfg_q.genSel == GEN_BOOST ? ctrl_q.contrast : 4'h0; // R7
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign segLevel = segLevel_q;
  assign comLevel = comLevel_q;
  assign sharedIsCom = sharedIsCom_q;
  assign genSel = genSel_q;
  assign refLevel = refLevel_q;

endmodule // lcdm_drive_top

/* core/lcdm_pkg.sv */
// Function
// R1: reset clears the drive mode register to zero.
// R2: software writes the drive mode register only as a whole byte.
// R3: bits 7:6 pick resistor division, boosting or capacitor split; 11 prohibited.
// R4: bit 5 picks drive waveform style A or B.
// R5: slice field codes static,2,3,4,6,8 as 000..101; others prohibited.
// R6: bias field codes half, third, quarter as 00,01,10; 11 prohibited.
// R7: boosting offers sixteen selectable reference levels for contrast.
// R8: display memory is fetched automatically, no processor work per frame.
// R9: a blinking display mode is supported.
// R10: commons four to seven share pins with segments zero to three.
// R11: eight commons leave thirty-two segments on the large variant.
// R12: six slices use six commons and thirty-four segments, large variant.
// R13: static uses one common, all segments, waveform A and resistor division.
// R14: half bias only waveform A, resistor division, two or three slices.
// R15: waveform B allows third bias at 3,4,6,8, quarter only at 8.
// R16: reduced variant has 27 segments, 23 with eight commons.
// R17: prohibited codes or combinations hold all outputs inactive.
package lcdm_pkg;

  // ==========================================================
  // register map (byte addresses, low 20 bits decoded)
  localparam logic [19:0] MODE_CFG_OFS = 20'hfff40;
  localparam logic [19:0] CTRL_OFS = 20'hfff44;
  localparam logic [19:0] STATUS_OFS = 20'hfff48;
  localparam logic [19:0] DMEM_BASE = 20'hffe00;
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ==========================================================
  // field codes
  localparam logic [1:0] GEN_EXT = 2'h0;
  localparam logic [1:0] GEN_BOOST = 2'h1;
  localparam logic [1:0] GEN_CAP = 2'h2;
  localparam logic [2:0] SLICE_STATIC = 3'h0;
  localparam logic [2:0] SLICE_2 = 3'h1;
  localparam logic [2:0] SLICE_3 = 3'h2;
  localparam logic [2:0] SLICE_4 = 3'h3;
  localparam logic [2:0] SLICE_6 = 3'h4;
  localparam logic [2:0] SLICE_8 = 3'h5;
  localparam logic [1:0] BIAS_HALF = 2'h0;
  localparam logic [1:0] BIAS_THIRD = 2'h1;
  localparam logic [1:0] BIAS_QUARTER = 2'h2;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLICE_TIME_US = 1000;
  localparam int SLICE_CYCLES_DFLT = SLICE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BLINK_FRAMES = 32;
  localparam int LVL_W = 3;
  localparam int SHARED_PINS = 4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] genSel;
    logic waveB;
    logic [2:0] slice;
    logic [1:0] bias;
  } lcdm_mode_cfg_t;

  typedef struct packed {
    logic [3:0] contrast;
    logic [1:0] rsvd;
    logic blinkEn;
    logic dispOn;
  } lcdm_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [3:0] comCount;
    logic [2:0] biasDen;
    logic [5:0] segCount;
  } lcdm_mode_t;

  typedef struct packed {
    logic [14:0] zero;
    logic [5:0] segCount;
    logic [3:0] comCount;
    logic pol;
    logic [2:0] slice;
    logic blank;
    logic run;
    logic valid;
  } lcdm_status_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_BLANK = 3'b100
  } lcdm_state_t;

endpackage

/* core/lcdm_mode_decode.sv */
`timescale 1ns/10ps
module lcdm_mode_decode #(
  parameter int SEG_NUM = 36
) (
  input wire lcdm_pkg::lcdm_mode_cfg_t cfg,
  output lcdm_pkg::lcdm_mode_t mode
);
  import lcdm_pkg::*;

  // ==========================================================
  // legal combinations
  wire genOk = cfg.genSel != 2'h3; // R3
  wire isExt = cfg.genSel == GEN_EXT;
  wire sliceMulti = cfg.slice == SLICE_3 || cfg.slice == SLICE_4
    || cfg.slice == SLICE_6 || cfg.slice == SLICE_8; // R5
  wire staticOk = cfg.slice == SLICE_STATIC && cfg.bias == BIAS_HALF
    && !cfg.waveB && isExt; // R13
  wire halfOk = cfg.bias == BIAS_HALF && !cfg.waveB && isExt
    && (cfg.slice == SLICE_2 || cfg.slice == SLICE_3); // R14
  wire thirdOk = cfg.bias == BIAS_THIRD && sliceMulti; // R15
  wire quarterOk = cfg.bias == BIAS_QUARTER && cfg.genSel != GEN_CAP
    && (cfg.slice == SLICE_8
    || (cfg.slice == SLICE_6 && !cfg.waveB
    && cfg.genSel == GEN_BOOST)); // R15
  // prohibited slice and bias codes never match any term above
  wire modeOk = genOk && (staticOk || halfOk || thirdOk || quarterOk); // R17

  // ==========================================================
  // geometry
  wire [3:0] comCount = cfg.slice == SLICE_2 ? 4'h2 :
    cfg.slice == SLICE_3 ? 4'h3 :
    cfg.slice == SLICE_4 ? 4'h4 :
    cfg.slice == SLICE_6 ? 4'h6 :
    cfg.slice == SLICE_8 ? 4'h8 : 4'h1; // R5
  wire [2:0] biasDen = cfg.slice == SLICE_STATIC ? 3'h1 :
    cfg.bias == BIAS_HALF ? 3'h2 :
    cfg.bias == BIAS_THIRD ? 3'h3 : 3'h4; // R6
  // shared pins turned commons are lost as segments
  wire [5:0] segCount = comCount == 4'h8 ? 6'(SEG_NUM - 4) :
    comCount == 4'h6 ? 6'(SEG_NUM - 2) : 6'(SEG_NUM); // R11 R12 R16

  assign mode.valid = modeOk;
  assign mode.comCount = comCount;
  assign mode.biasDen = biasDen;
  assign mode.segCount = segCount;

endmodule // lcdm_mode_decode

/* testbench/lcdm_panel_model.sv */
`timescale 1ns/10ps
module lcdm_panel_model
  import lcdm_pkg::*;
#(
  parameter int SEG_NUM = 36
) (
  input wire logic [SEG_NUM-1:0][LVL_W-1:0] segLevel,
  input wire logic [3:0][LVL_W-1:0] comLevel,
  input wire logic [3:0] sharedIsCom,
  output logic pixelLit
);
  // ==========================================================
  // passive glass: a pixel darkens when its segment and common differ
  // pin 0 counts as a segment only while it is not a common
  assign pixelLit = !sharedIsCom[0] && (segLevel[0] != comLevel[0]);
endmodule // lcdm_panel_model

/* testbench/lcdm_drive_top_sva.sv */
`timescale 1ns/10ps
module lcdm_drive_top_sva
  import lcdm_pkg::*;
#(
  parameter int SEG_NUM = 36
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [SEG_NUM-1:0][LVL_W-1:0] segLevel,
  input wire logic [3:0][LVL_W-1:0] comLevel,
  input wire logic [3:0] sharedIsCom,
  input wire logic [1:0] genSel,
  input wire logic [3:0] refLevel
);
  // ==========================================================
  // shadow of mode and control, tracked from the bus
  logic apWr_q;
  logic [19:0] apAddr_q;
  logic [7:0] cfg_q;
  logic [7:0] ctl_q;
  wire apTaken = hsel && htrans[1] && hready;
  wire badCode = cfg_q[7:6] == 2'h3 || cfg_q[4:2] > SLICE_8 || cfg_q[1:0] == 2'h3;
  wire idleWant = badCode || !ctl_q[0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apWr_q <= 1'b0;
      apAddr_q <= 20'h0;
      cfg_q <= MODE_CFG_RST;
      ctl_q <= CTRL_RST;
    end else begin
      apWr_q <= apTaken && hwrite;
      apAddr_q <= haddr[19:0];
      if (apWr_q && apAddr_q == MODE_CFG_OFS) cfg_q <= hwdata[7:0];
      if (apWr_q && apAddr_q == CTRL_OFS) ctl_q <= hwdata[7:0];
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // three cycles give the state machine room to wind down
  sequence idle_hold_s; idleWant [*3]; endsequence
  sequence read_mode_s; apTaken && !hwrite && haddr[19:0] == MODE_CFG_OFS; endsequence
  reset_clear_a: assert property ($fell(rst) |-> genSel == 2'h0 && sharedIsCom == 4'h0
    && refLevel == 4'h0) else $error("outputs not clear after reset");
  ready_high_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  gen_code_a: assert property (genSel != 2'h3) else $error("prohibited generator shown");
  ref_off_a: assert property ((genSel != GEN_BOOST) [*3] |-> refLevel == 4'h0)
    else $error("contrast step without boosting");
  shared_group_a: assert property (sharedIsCom inside {4'h0, 4'h3, 4'hf})
    else $error("shared pins split oddly");
  level_range_a: assert property (comLevel[0] <= 3'h4 && comLevel[3] <= 3'h4
    && segLevel[0] <= 3'h4) else $error("level beyond bias");
  illegal_idle_a: assert property (idle_hold_s |-> segLevel == '0 && comLevel == '0
    && sharedIsCom == 4'h0) else $error("outputs active while idle");
  gen_illegal_a: assert property (badCode [*3] |-> genSel == 2'h0 && refLevel == 4'h0)
    else $error("generator shown for prohibited code");
  cfg_width_a: assert property (read_mode_s |=> hrdata[31:8] == 24'h0)
    else $error("mode register wider than a byte");
endmodule // lcdm_drive_top_sva

bind lcdm_drive_top lcdm_drive_top_sva #(.SEG_NUM(SEG_NUM)) u_sva (.clk(clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .segLevel(segLevel), .comLevel(comLevel), .sharedIsCom(sharedIsCom), .genSel(genSel),
  .refLevel(refLevel));

/* testbench/tb_lcdm_drive_top.sv */
`timescale 1ns/10ps
module tb_lcdm_drive_top;
  import lcdm_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] gen;
    logic [3:0] shr;
    logic legal;
    logic [3:0] com;
    logic [5:0] seg;
  } lcdm_row_t;
  localparam lcdm_row_t ROWS [15] = '{
    '{8'h00, 2'h0, 4'h0, 1'b1, 4'h1, 6'h24}, '{8'h04, 2'h0, 4'h0, 1'b1, 4'h2, 6'h24},
    '{8'h08, 2'h0, 4'h0, 1'b1, 4'h3, 6'h24}, '{8'h55, 2'h1, 4'hf, 1'b1, 4'h8, 6'h20},
    '{8'h8d, 2'h2, 4'h0, 1'b1, 4'h4, 6'h24}, '{8'h36, 2'h0, 4'hf, 1'b1, 4'h8, 6'h20},
    '{8'h11, 2'h0, 4'h3, 1'b1, 4'h6, 6'h22}, '{8'h52, 2'h1, 4'h3, 1'b1, 4'h6, 6'h22},
    '{8'h2d, 2'h0, 4'h0, 1'b1, 4'h4, 6'h24}, '{8'hcd, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00},
    '{8'h19, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00}, '{8'h03, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00},
    '{8'h24, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00}, '{8'h96, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00},
    '{8'h44, 2'h0, 4'h0, 1'b0, 4'h0, 6'h00}};
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, pixelLit, blank;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, genSel;
  logic [2:0] hsize;
  logic [35:0][LVL_W-1:0] segLevel;
  logic [3:0][LVL_W-1:0] comLevel;
  logic [3:0] sharedIsCom, refLevel;
  int failures = 0;
  int checked = 0;
  assign hready = hreadyout;
  lcdm_drive_top #(.SEG_NUM(36), .SLICE_CYCLES(8), .BLINK_FRAMES(2)) u_dut (.clk(clk),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .segLevel(segLevel), .comLevel(comLevel), .sharedIsCom(sharedIsCom), .genSel(genSel),
    .refLevel(refLevel));
  lcdm_panel_model #(.SEG_NUM(36)) u_panel (.segLevel(segLevel), .comLevel(comLevel),
    .sharedIsCom(sharedIsCom), .pixelLit(pixelLit));
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask
  // whole-byte writes only, never bit fiddling
  task automatic bus_write(input logic [19:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {12'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask
  // hrdata is taken at the edge that ends the data phase
  task automatic bus_read(input logic [19:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {12'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    failures++;
    print_verdict();
  end
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, blank} = 69'h0;
    rst = 1'b1;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_read(MODE_CFG_OFS, rd);
    check("mode at reset", rd, 32'h0);
    bus_read(20'h00100, rd);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 15; i++) begin
      bus_write(MODE_CFG_OFS, ROWS[i].cfg);
      bus_write(CTRL_OFS, 8'ha1);
      repeat (4) @(posedge clk);
      check("generator", {30'h0, genSel}, {30'h0, ROWS[i].gen});
      check("shared", {28'h0, sharedIsCom}, {28'h0, ROWS[i].shr});
      check("contrast", {28'h0, refLevel}, ROWS[i].gen == GEN_BOOST ? 32'ha : 32'h0);
      bus_read(MODE_CFG_OFS, rd);
      check("mode", rd, {24'h0, ROWS[i].cfg});
      bus_read(STATUS_OFS, rd);
      check("legal", {31'h0, rd[0]}, {31'h0, ROWS[i].legal});
      if (ROWS[i].legal) check("counts", {22'h0, rd[16:7]}, {22'h0, ROWS[i].seg, ROWS[i].com});
      else check("idle", {31'h0, |{segLevel, comLevel}}, 32'h0);
      bus_write(CTRL_OFS, 8'h00);
    end
    bus_write(DMEM_BASE, 8'h01);
    bus_write(DMEM_BASE + 20'h4, 8'h00);
    bus_write(MODE_CFG_OFS, 8'h00);
    bus_write(CTRL_OFS, 8'h01);
    repeat (4) @(posedge clk);
    check("seg on", {29'h0, segLevel[0] ^ comLevel[0]}, 32'h1);
    check("seg off", {29'h0, segLevel[1] ^ comLevel[0]}, 32'h0);
    check("pixel", {31'h0, pixelLit}, 32'h1);
    bus_write(CTRL_OFS, 8'h03);
    for (int n = 0; n < 400 && !blank; n++) begin
      bus_read(STATUS_OFS, rd);
      blank = rd[2];
    end
    check("blink", {31'h0, blank}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("levels reset", {31'h0, |{segLevel, comLevel}}, 32'h0);
    bus_read(MODE_CFG_OFS, rd);
    check("mode reset", rd, 32'h0);
    print_verdict();
  end
endmodule // tb_lcdm_drive_top
